// ---- src/adc_input_mux_mode_config.sv ----
// Purpose: register file and mux pairing decode for an eight-input converter front end
// Assumes: reads answer one cycle after the read strobe; alert and error are synchronous
// Notes:   sequencer internals are outside; seq_running tracks start, abort, manual channel writes and mode writes
//
// Behaviour
// R1 - pair 0/1 field 00b or 11b: separate inputs, negative output on common input
// R2 - pair 0/1 field 01b: single-ended pair, input 0 positive, input 1 negative
// R3 - pair 0/1 field 10b: pseudo-differential pair, input 0 positive, 1 negative
// R4 - bits 5-4 pair inputs 2 and 3 the same way, input 2 positive
// R5 - bits 3-2 pair inputs 4 and 5 the same way, input 4 positive
// R6 - bits 1-0 pair inputs 6 and 7; 11b acts like 00b
// R7 - common select: unpaired channels single-ended when 0, pseudo-differential when 1
// R8 - common select affects only pairs set to 00b or 11b
// R9 - common register bits 7-1 read zero; only bit 0 writable
// R10 - mode register bits 7-4 read zero; host must not write them
// R11 - mode register bit 3 mirrors the alert pin level
// R12 - mode register bit 2 reads one on configuration error
// R13 - mode field bits 1-0: manual, on-the-fly, automatic, custom
// R14 - mode register read returns alert, error and mode in one byte
// R15 - common at 27h, pairing at 24h, mode at 1Ch, all reset to zero
// R16 - start register at 1Eh and abort register at 1Fh are decoded
// R17 - scan enable at 80h and scan repeat at 82h are decoded
// R18 - manual channel write during auto or custom sequence aborts, forces manual
// R19 - start and abort writes ignored in manual or on-the-fly mode
// R20 - writes leave read-only and reserved bits unchanged
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module adc_input_mux_mode_config (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire mux_cfg_pkg::reg_req_t      req,
    input  wire logic                       alert_level,
    input  wire logic                       config_error,
    output logic [7:0]                      rdata,
    output mux_cfg_pkg::seq_mode_t          sequencing_mode,
    output mux_cfg_pkg::pair_route_t        pair_route,
    output logic                            common_pseudo,
    output logic [7:0]                      unpaired_pseudo,
    output logic [2:0]                      manual_channel_select,
    output logic                            fast_select_enable,
    output logic [7:0]                      auto_scan_channel_enable,
    output logic [7:0]                      auto_scan_repeat_ctrl,
    output logic                            seq_running,
    output logic                            sequence_start_ctrl_pulse,
    output logic                            seq_abort_pulse
);

    logic [7:0]                 input_pairing_config;
    logic                       common_input_config;
    logic                       alert_seen;
    logic                       error_seen;
    logic                       wr_mode;
    logic                       wr_chan;
    logic                       seq_mode_active;
    mux_cfg_pkg::pair_route_t   next_route;
    logic [7:0]                 next_unpaired;
    logic [7:0]                 next_rdata;

    assign wr_mode = req.wr && (req.addr == mux_cfg_pkg::ADDR_MODE_STATUS);
    assign wr_chan = req.wr && (req.addr == mux_cfg_pkg::ADDR_MANUAL_CH);
    assign seq_mode_active = (sequencing_mode == mux_cfg_pkg::MODE_AUTO)
                          || (sequencing_mode == mux_cfg_pkg::MODE_CUSTOM); // R19

    // status mirrors
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_seen <= 1'b0;
            error_seen <= 1'b0;
        end else begin
            alert_seen <= alert_level;  // R11
            error_seen <= config_error; // R12
        end
    end

    // sequencing mode field
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sequencing_mode <= mux_cfg_pkg::MODE_MANUAL; // R15
        end else if (wr_mode) begin
            sequencing_mode <= mux_cfg_pkg::seq_mode_t'(req.wdata[1:0]); // R13 R20
        end else if (wr_chan && seq_running) begin
            sequencing_mode <= mux_cfg_pkg::MODE_MANUAL; // R18
        end
    end

    // sequence run state, start and abort strobes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_running     <= 1'b0;
            sequence_start_ctrl_pulse <= 1'b0;
            seq_abort_pulse <= 1'b0;
        end else begin
            sequence_start_ctrl_pulse <= req.wr && (req.addr == mux_cfg_pkg::ADDR_SEQUENCE_START_CTRL)
                               && req.wdata[0] && seq_mode_active; // R16 R19
            seq_abort_pulse <= (req.wr && (req.addr == mux_cfg_pkg::ADDR_SEQ_ABORT)
                               && req.wdata[0] && seq_mode_active)
                               || (wr_chan && seq_running); // R16 R18
            if (wr_chan && seq_running) begin
                seq_running <= 1'b0; // R18
            end else if (wr_mode && !(req.wdata[1] == 1'b1)) begin
                seq_running <= 1'b0;
            end else if (req.wr && seq_mode_active && req.wdata[0]
                         && (req.addr == mux_cfg_pkg::ADDR_SEQ_ABORT)) begin
                seq_running <= 1'b0; // R19
            end else if (req.wr && seq_mode_active && req.wdata[0]
                         && (req.addr == mux_cfg_pkg::ADDR_SEQUENCE_START_CTRL)) begin
                seq_running <= 1'b1; // R19
            end
        end
    end

    // writable configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_pairing_config     <= mux_cfg_pkg::RESET_BYTE; // R15
            common_input_config      <= 1'b0; // R15
            manual_channel_select    <= 3'h0;
            fast_select_enable       <= 1'b0;
            auto_scan_channel_enable <= mux_cfg_pkg::RESET_BYTE;
            auto_scan_repeat_ctrl    <= mux_cfg_pkg::RESET_BYTE;
        end else if (req.wr) begin
            unique case (req.addr)
                mux_cfg_pkg::ADDR_PAIRING:     input_pairing_config <= req.wdata;
                mux_cfg_pkg::ADDR_COMMON:      common_input_config <= req.wdata[0]; // R9
                mux_cfg_pkg::ADDR_MANUAL_CH:   manual_channel_select <= req.wdata[2:0];
                mux_cfg_pkg::ADDR_FAST_SELECT: fast_select_enable <= req.wdata[0];
                mux_cfg_pkg::ADDR_SCAN_ENABLE: auto_scan_channel_enable <= req.wdata; // R17
                mux_cfg_pkg::ADDR_SCAN_REPEAT: auto_scan_repeat_ctrl <= req.wdata; // R17
                default: ;
            endcase
        end
    end

    // pairing decode, one field per input pair
    always_comb begin
        logic [1:0] field;
        field         = 2'b00;
        next_route    = '0;
        next_unpaired = '0;
        for (int p = 0; p < 4; p++) begin
            field = input_pairing_config[mux_cfg_pkg::PAIR01_HI - 2*p -: 2]; // R1 R4 R5 R6
            next_route.paired[p] = (field == mux_cfg_pkg::PAIR_SINGLE)
                                || (field == mux_cfg_pkg::PAIR_PSEUDO); // R2 R3
            next_route.pseudo[p] = next_route.paired[p] ? (field == mux_cfg_pkg::PAIR_PSEUDO)
                                                        : common_input_config; // R7 R8
            next_unpaired[2*p]   = !next_route.paired[p] && common_input_config; // R8
            next_unpaired[2*p+1] = !next_route.paired[p] && common_input_config; // R8
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pair_route      <= '0;
            unpaired_pseudo <= '0;
            common_pseudo   <= 1'b0;
        end else begin
            pair_route      <= next_route;
            unpaired_pseudo <= next_unpaired;
            common_pseudo   <= common_input_config; // R7
        end
    end

    // read path
    always_comb begin
        next_rdata = mux_cfg_pkg::RESET_BYTE;
        unique case (req.addr)
            mux_cfg_pkg::ADDR_MODE_STATUS: next_rdata = {4'h0, alert_seen, error_seen,
                                                          sequencing_mode}; // R10 R14
            mux_cfg_pkg::ADDR_MANUAL_CH:   next_rdata = {5'h00, manual_channel_select};
            mux_cfg_pkg::ADDR_PAIRING:     next_rdata = input_pairing_config;
            mux_cfg_pkg::ADDR_COMMON:      next_rdata = {7'h00, common_input_config}; // R9
            mux_cfg_pkg::ADDR_FAST_SELECT: next_rdata = {7'h00, fast_select_enable};
            mux_cfg_pkg::ADDR_SCAN_ENABLE: next_rdata = auto_scan_channel_enable;
            mux_cfg_pkg::ADDR_SCAN_REPEAT: next_rdata = auto_scan_repeat_ctrl;
            default:                       next_rdata = mux_cfg_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= mux_cfg_pkg::RESET_BYTE;
        end else begin
            rdata <= req.rd ? next_rdata : mux_cfg_pkg::RESET_BYTE;
        end
    end

    // checks
    property p_pair_single;
        @(posedge core_clk) disable iff (!rst_n)
        input_pairing_config[7:6] == 2'b01 |=> pair_route.paired[0] && !pair_route.pseudo[0];
    endproperty
    a_pair_single: assert property (p_pair_single) else $error("pair single wrong"); // R2

    property p_pair_pseudo;
        @(posedge core_clk) disable iff (!rst_n)
        input_pairing_config[7:6] == 2'b10 |=> pair_route.paired[0] && pair_route.pseudo[0];
    endproperty
    a_pair_pseudo: assert property (p_pair_pseudo) else $error("pair pseudo wrong"); // R3

    property p_sep_common;
        @(posedge core_clk) disable iff (!rst_n)
        (input_pairing_config[1:0] == 2'b11) |=>
            !pair_route.paired[3] && unpaired_pseudo[7] == $past(common_input_config);
    endproperty
    a_sep_common: assert property (p_sep_common) else $error("separate pair wrong"); // R6

    property p_mode_read;
        @(posedge core_clk) disable iff (!rst_n)
        req.rd && req.addr == mux_cfg_pkg::ADDR_MODE_STATUS |=>
            rdata == {4'h0, $past(alert_seen), $past(error_seen), $past(sequencing_mode)};
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read wrong"); // R14

    property p_alert_mirror;
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> alert_seen == $past(alert_level);
    endproperty
    a_alert_mirror: assert property (p_alert_mirror) else $error("alert mirror stale"); // R11

    property p_com_read;
        @(posedge core_clk) disable iff (!rst_n)
        req.rd && req.addr == mux_cfg_pkg::ADDR_COMMON |=> rdata[7:1] == 7'h00;
    endproperty
    a_com_read: assert property (p_com_read) else $error("reserved bits set"); // R9

    property p_chan_abort;
        @(posedge core_clk) disable iff (!rst_n)
        wr_chan && seq_running && !wr_mode |=>
            sequencing_mode == mux_cfg_pkg::MODE_MANUAL && !seq_running && seq_abort_pulse;
    endproperty
    a_chan_abort: assert property (p_chan_abort) else $error("no abort on channel write"); // R18

    property p_start_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_SEQUENCE_START_CTRL && !seq_mode_active
            |=> !sequence_start_ctrl_pulse && !$rose(seq_running);
    endproperty
    a_start_ignored: assert property (p_start_ignored) else $error("start not ignored"); // R19

    property p_pair_sep;
        @(posedge core_clk) disable iff (!rst_n)
        input_pairing_config[7:6] == 2'b00 |=>
            !pair_route.paired[0] && unpaired_pseudo[1:0] == {2{$past(common_input_config)}};
    endproperty
    a_pair_sep: assert property (p_pair_sep) else $error("separate pair wrong"); // R1

    property p_pair23;
        @(posedge core_clk) disable iff (!rst_n)
        input_pairing_config[mux_cfg_pkg::PAIR23_HI -: 2] == 2'b10 |=>
            pair_route.paired[1] && pair_route.pseudo[1];
    endproperty
    a_pair23: assert property (p_pair23) else $error("pair 2/3 wrong"); // R4

    property p_pair45;
        @(posedge core_clk) disable iff (!rst_n)
        input_pairing_config[mux_cfg_pkg::PAIR45_HI -: 2] == 2'b01 |=>
            pair_route.paired[2] && !pair_route.pseudo[2];
    endproperty
    a_pair45: assert property (p_pair45) else $error("pair 4/5 wrong"); // R5

    property p_pair67;
        @(posedge core_clk) disable iff (!rst_n)
        input_pairing_config[mux_cfg_pkg::PAIR67_HI -: 2] == 2'b10 |=>
            pair_route.paired[3] && pair_route.pseudo[3];
    endproperty
    a_pair67: assert property (p_pair67) else $error("pair 6/7 wrong"); // R6

    property p_common_copy;
        @(posedge core_clk) disable iff (!rst_n)
        common_pseudo == $past(common_input_config);
    endproperty
    a_common_copy: assert property (p_common_copy) else $error("common copy stale"); // R7

    property p_unpaired_common;
        @(posedge core_clk) disable iff (!rst_n)
        !next_route.paired[2] |=> unpaired_pseudo[5:4] == {2{$past(common_input_config)}};
    endproperty
    a_unpaired_common: assert property (p_unpaired_common) else $error("unpaired mode wrong"); // R7

    property p_paired_ignores;
        @(posedge core_clk) disable iff (!rst_n)
        next_route.paired[1] |=> unpaired_pseudo[3:2] == 2'b00;
    endproperty
    a_paired_ignores: assert property (p_paired_ignores) else $error("pair took common"); // R8

    property p_com_write;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_COMMON |=>
            common_input_config == $past(req.wdata[0]);
    endproperty
    a_com_write: assert property (p_com_write) else $error("common write lost"); // R9

    property p_mode_reserved;
        @(posedge core_clk) disable iff (!rst_n)
        req.rd && req.addr == mux_cfg_pkg::ADDR_MODE_STATUS |=> rdata[7:4] == 4'h0;
    endproperty
    a_mode_reserved: assert property (p_mode_reserved) else $error("mode reserved set"); // R10

    property p_error_mirror;
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> error_seen == $past(config_error);
    endproperty
    a_error_mirror: assert property (p_error_mirror) else $error("error mirror stale"); // R12

    property p_error_read;
        @(posedge core_clk) disable iff (!rst_n)
        req.rd && req.addr == mux_cfg_pkg::ADDR_MODE_STATUS |=>
            rdata[mux_cfg_pkg::ERROR_BIT] == $past(error_seen);
    endproperty
    a_error_read: assert property (p_error_read) else $error("error bit wrong"); // R12

    property p_mode_write;
        @(posedge core_clk) disable iff (!rst_n)
        wr_mode |=> sequencing_mode == $past(req.wdata[1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // R13

    property p_mode_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !wr_mode && !(wr_chan && seq_running) |=> $stable(sequencing_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed unasked"); // R20

    property p_reset_zero;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> input_pairing_config == mux_cfg_pkg::RESET_BYTE
            && !common_input_config && sequencing_mode == mux_cfg_pkg::MODE_MANUAL;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong"); // R15

    property p_start_pulse;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_SEQUENCE_START_CTRL && req.wdata[0] && seq_mode_active
            |=> sequence_start_ctrl_pulse && seq_running;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start not taken"); // R16

    property p_abort_pulse;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_SEQ_ABORT && req.wdata[0] && seq_mode_active
            |=> seq_abort_pulse && !seq_running;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort not taken"); // R16

    property p_scan_write;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_SCAN_ENABLE |=>
            auto_scan_channel_enable == $past(req.wdata);
    endproperty
    a_scan_write: assert property (p_scan_write) else $error("scan enable lost"); // R17

    property p_repeat_write;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_SCAN_REPEAT |=>
            auto_scan_repeat_ctrl == $past(req.wdata);
    endproperty
    a_repeat_write: assert property (p_repeat_write) else $error("scan repeat lost"); // R17

    property p_abort_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_SEQ_ABORT && !seq_mode_active
            |=> !seq_abort_pulse && $stable(seq_running);
    endproperty
    a_abort_ignored: assert property (p_abort_ignored) else $error("abort not ignored"); // R19

    property p_chan_read;
        @(posedge core_clk) disable iff (!rst_n)
        req.rd && req.addr == mux_cfg_pkg::ADDR_MANUAL_CH |=> rdata[7:3] == 5'h00;
    endproperty
    a_chan_read: assert property (p_chan_read) else $error("channel reserved set"); // R20

    property p_fly_read;
        @(posedge core_clk) disable iff (!rst_n)
        req.rd && req.addr == mux_cfg_pkg::ADDR_FAST_SELECT |=> rdata[7:1] == 7'h00;
    endproperty
    a_fly_read: assert property (p_fly_read) else $error("fast select reserved set"); // R20

    property p_pairing_write;
        @(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == mux_cfg_pkg::ADDR_PAIRING |=>
            input_pairing_config == $past(req.wdata);
    endproperty
    a_pairing_write: assert property (p_pairing_write) else $error("pairing write lost"); // R1

    c_start:  cover property (@(posedge core_clk) disable iff (!rst_n) $rose(seq_running));
    c_abort:  cover property (@(posedge core_clk) disable iff (!rst_n) seq_abort_pulse);
    c_paired: cover property (@(posedge core_clk) disable iff (!rst_n) &pair_route.paired);
    c_pseudo: cover property (@(posedge core_clk) disable iff (!rst_n) &pair_route.pseudo);
    c_chan:   cover property (@(posedge core_clk) disable iff (!rst_n) wr_chan && seq_running);

endmodule : adc_input_mux_mode_config

// ---- src/mux_cfg_pkg.sv ----
// Purpose: shared constants and types for the input multiplexer configuration block
// Assumes: 8-bit register port with byte addresses
// Notes:   one package, referenced by scope only
package mux_cfg_pkg;

    localparam logic [7:0] ADDR_MODE_STATUS  = 8'h1C;
    localparam logic [7:0] ADDR_MANUAL_CH    = 8'h1D;
    localparam logic [7:0] ADDR_SEQUENCE_START_CTRL    = 8'h1E;
    localparam logic [7:0] ADDR_SEQ_ABORT    = 8'h1F;
    localparam logic [7:0] ADDR_PAIRING      = 8'h24;
    localparam logic [7:0] ADDR_COMMON       = 8'h27;
    localparam logic [7:0] ADDR_FAST_SELECT  = 8'h2A;
    localparam logic [7:0] ADDR_SCAN_ENABLE  = 8'h80;
    localparam logic [7:0] ADDR_SCAN_REPEAT  = 8'h82;

    localparam logic [7:0] RESET_BYTE        = 8'h00;
    localparam int         ALERT_BIT         = 3;
    localparam int         ERROR_BIT         = 2;
    localparam int         PAIR01_HI         = 7;
    localparam int         PAIR23_HI         = 5;
    localparam int         PAIR45_HI         = 3;
    localparam int         PAIR67_HI         = 1;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_FLY    = 2'b01,
        MODE_AUTO   = 2'b10,
        MODE_CUSTOM = 2'b11
    } seq_mode_t;

    typedef enum logic [1:0] {
        PAIR_SEPARATE = 2'b00,
        PAIR_SINGLE   = 2'b01,
        PAIR_PSEUDO   = 2'b10,
        PAIR_SAME_SEP = 2'b11
    } pair_setting_t;

    // register access request from the host side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // per-pair routing result: 1 = paired, 1 = pseudo-differential
    typedef struct packed {
        logic [3:0] paired;
        logic [3:0] pseudo;
    } pair_route_t;

endpackage : mux_cfg_pkg

// ---- tb/host_model.sv ----
// Purpose: host controller model driving the register port
// Assumes: strobes last one cycle, read data stand in the cycle after the read strobe
// Notes:   an idle bus shows the inverse of the last address and data
`timescale 1ns/1ps
module host_model (
    input  wire logic                  core_clk,
    input  wire logic [7:0]            rdata,
    output mux_cfg_pkg::reg_req_t      req
);
    initial req = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        // reserved mode bits are never written
        req <= '{addr: a, wdata: (a == 8'h1C) ? (d & 8'h0F) : d,
                 wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        @(negedge core_clk);
        d = rdata;
    endtask : rd
endmodule : host_model

// ---- tb/adc_input_mux_mode_config_tb_top.sv ----
// Purpose: self-checking bench for the mux pairing and mode registers
// Assumes: host model drives the register port
// Notes:   pulses are counted on every rising clock edge
`timescale 1ns/1ps
module adc_input_mux_mode_config_tb_top;
    logic                      core_clk, rst_n, alert_level, config_error;
    logic                      common_pseudo, fast_select_enable, seq_running;
    logic                      sequence_start_ctrl_pulse, seq_abort_pulse;
    logic [2:0]                manual_channel_select;
    logic [7:0]                rdata, unpaired_pseudo, auto_scan_channel_enable, rd_val;
    logic [7:0]                auto_scan_repeat_ctrl;
    mux_cfg_pkg::reg_req_t     req;
    mux_cfg_pkg::seq_mode_t    sequencing_mode;
    mux_cfg_pkg::pair_route_t  pair_route;
    int                        err_count = 0, n_tests = 0, n_start = 0, n_abort = 0;

    adc_input_mux_mode_config adc_input_mux_mode_config_i (
        .core_clk, .rst_n, .req, .alert_level, .config_error, .rdata, .sequencing_mode,
        .pair_route, .common_pseudo, .unpaired_pseudo, .manual_channel_select,
        .fast_select_enable, .auto_scan_channel_enable, .auto_scan_repeat_ctrl,
        .seq_running, .sequence_start_ctrl_pulse, .seq_abort_pulse
    );
    host_model host_model_i (.core_clk, .rdata, .req);

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (sequence_start_ctrl_pulse === 1'b1) n_start++;
        if (seq_abort_pulse === 1'b1) n_abort++;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        host_model_i.rd(a, rd_val);
        chk(nm, rd_val, exp);
    endtask : rdchk

    task automatic settle;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    task automatic t_reset;
        chk("route", pair_route, 8'h00);
        rdchk("mode", 8'h1C, 8'h00);
        rdchk("pairing", 8'h24, 8'h00);
        rdchk("common", 8'h27, 8'h00);
    endtask : t_reset

    task automatic pair_case(input logic [7:0] w, input logic [3:0] pd, input logic [3:0] ps,
                             input logic [7:0] up);
        host_model_i.wr(8'h24, w);
        settle();
        chk("paired", {4'h0, pair_route.paired}, {4'h0, pd});
        chk("pseudo", {4'h0, pair_route.pseudo & pd}, {4'h0, ps});
        chk("unpaired", unpaired_pseudo, up);
        rdchk("pairing", 8'h24, w);
    endtask : pair_case

    task automatic t_pairs;
        host_model_i.wr(8'h27, 8'hFF);
        settle();
        chk("common_pseudo", {7'h0, common_pseudo}, 8'h01);
        rdchk("common", 8'h27, 8'h01);
        pair_case(8'h00, 4'h0, 4'h0, 8'hFF);
        pair_case(8'h55, 4'hF, 4'h0, 8'h00);
        pair_case(8'hAA, 4'hF, 4'hF, 8'h00);
        pair_case(8'hFF, 4'h0, 4'h0, 8'hFF);
        pair_case(8'h63, 4'h3, 4'h2, 8'hF0);
        pair_case(8'hC9, 4'hC, 4'h4, 8'h0F);
        host_model_i.wr(8'h27, 8'h00);
        settle();
        chk("unpaired", unpaired_pseudo, 8'h00);
    endtask : t_pairs

    task automatic t_mode;
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            alert_level <= i[3];
            config_error <= i[2];
            host_model_i.wr(8'h1C, {4'h0, ~i[3:2], i[1:0]});
            settle();
            chk("mode", {6'h0, sequencing_mode}, {6'h0, i[1:0]});
            rdchk("status", 8'h1C, {4'h0, i[3:0]});
        end
    endtask : t_mode

    task automatic t_seq;
        for (int m = 0; m < 4; m++) begin
            host_model_i.wr(8'h1C, m[7:0]);
            host_model_i.wr(8'h1E, 8'h01);
            settle();
            chk("running", {7'h0, seq_running}, {7'h0, m[1]});
            host_model_i.wr(8'h1F, 8'h01);
            settle();
            chk("running", {7'h0, seq_running}, 8'h00);
        end
        chk("starts", n_start[7:0], 8'h02);
        chk("aborts", n_abort[7:0], 8'h02);
        host_model_i.wr(8'h1C, 8'h03);
        host_model_i.wr(8'h1E, 8'h01);
        host_model_i.wr(8'h1D, 8'hFD);
        settle();
        chk("mode", {6'h0, sequencing_mode}, 8'h00);
        chk("running", {7'h0, seq_running}, 8'h00);
        chk("aborts", n_abort[7:0], 8'h03);
        rdchk("channel", 8'h1D, 8'h05);
        chk("channel_out", {5'h00, manual_channel_select}, 8'h05);
    endtask : t_seq

    task automatic t_map;
        host_model_i.wr(8'h80, 8'hA5);
        host_model_i.wr(8'h82, 8'h3C);
        host_model_i.wr(8'h2A, 8'hFF);
        host_model_i.wr(8'h55, 8'hFF);
        settle();
        chk("scan_repeat", auto_scan_repeat_ctrl, 8'h3C);
        chk("scan_enable_out", auto_scan_channel_enable, 8'hA5);
        chk("fast_out", {7'h00, fast_select_enable}, 8'h01);
        rdchk("scan_enable", 8'h80, 8'hA5);
        rdchk("fast", 8'h2A, 8'h01);
        rdchk("unmapped", 8'h55, 8'h00);
    endtask : t_map

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    initial begin
        rst_n = 1'b0;
        alert_level = 1'b0;
        config_error = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        t_reset();
        t_pairs();
        t_mode();
        t_seq();
        t_map();
        report_and_stop();
    end

    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule : adc_input_mux_mode_config_tb_top
